/* logic/uxa_pkg.sv */
// Constants shared by the translation entry access block.
// Assumes bit 0 of the printed layouts is the most significant bit of a word.
package uxa_pkg;

    // Special register selector codes
    localparam int          UXA_SEL_W      = 16;
    localparam logic [15:0] UXA_SEL_INDEX  = 16'h1002;
    localparam logic [15:0] UXA_SEL_LOW    = 16'h1003;
    localparam logic [15:0] UXA_SEL_HIGH   = 16'h1004;
    localparam logic [15:0] UXA_SEL_SEARCH = 16'h1005;

    // Low word fields
    localparam int UXA_LO_PAGE_MSB = 31;
    localparam int UXA_LO_PAGE_LSB = 10;
    localparam int UXA_LO_FETCH    = 9;
    localparam int UXA_LO_WR       = 8;
    localparam int UXA_LO_ZONE_MSB = 7;
    localparam int UXA_LO_ZONE_LSB = 4;
    localparam int UXA_LO_W        = 3;
    localparam int UXA_LO_I        = 2;
    localparam int UXA_LO_M        = 1;
    localparam int UXA_LO_G        = 0;

    // High word fields
    localparam int UXA_HI_TAG_MSB  = 31;
    localparam int UXA_HI_TAG_LSB  = 10;
    localparam int UXA_HI_SIZE_MSB = 9;
    localparam int UXA_HI_SIZE_LSB = 7;
    localparam int UXA_HI_V        = 6;
    localparam int UXA_HI_E        = 5;
    localparam int UXA_HI_CUSTOM   = 4;
    localparam int UXA_HI_RSV_MSB  = 3;

    // Index register and widths
    localparam int          UXA_IX_MISS     = 31;
    localparam int          UXA_VPN_W       = 22;
    localparam int          UXA_OFS_W       = 10;
    localparam logic [31:0] UXA_ENTRY_RESET = 32'h00000000;

    // Configuration levels
    localparam int UXA_MMU_USER    = 1;
    localparam int UXA_MMU_VIRTUAL = 3;
    localparam int UXA_AREA_PERF   = 0;
    localparam int UXA_AREA_FREQ   = 2;
    localparam int UXA_ACC_MINIMAL = 0;

    // Zone override codes
    localparam logic [1:0] UXA_ZP_DENY  = 2'h0;
    localparam logic [1:0] UXA_ZP_GRANT = 2'h3;
    localparam int         UXA_ZP_PRIV  = 1;

    // Page-number bits compared for a size code, four times larger per step
    function automatic logic [UXA_VPN_W-1:0] uxa_vpn_mask(input logic [2:0] size);
        logic [UXA_VPN_W-1:0] m;
        m = '1;
        m = m << {size, 1'b0};
        return m;
    endfunction : uxa_vpn_mask

endpackage : uxa_pkg

/* logic/uxa_match.sv */
// Associative compare of a page number against every buffer entry.
// Assumes flattened high words and owner tags from the entry store.
`timescale 1ns/1ps
module uxa_match #(
    parameter int ENTRIES = 64,
    parameter int IDX_W   = 6,
    parameter int TAG_W   = 8
) (
    input  wire logic [ENTRIES*32-1:0]       hi_flat,
    input  wire logic [ENTRIES*TAG_W-1:0]    owner_flat,
    input  wire logic [uxa_pkg::UXA_VPN_W-1:0] vpn,
    input  wire logic [TAG_W-1:0]            ptag,
    output logic                             hit,
    output logic [IDX_W-1:0]                 idx
);
    import uxa_pkg::*;

    // Lowest matching index wins; owner tag zero matches any process
    always_comb begin
        logic [31:0]          h;
        logic [TAG_W-1:0]     t;
        logic [UXA_VPN_W-1:0] m;
        h   = '0;
        t   = '0;
        m   = '0;
        hit = 1'b0;
        idx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            h = hi_flat[i*32 +: 32];
            t = owner_flat[i*TAG_W +: TAG_W];
            m = uxa_vpn_mask(h[UXA_HI_SIZE_MSB:UXA_HI_SIZE_LSB]);
            if (h[UXA_HI_V]
                && ((h[UXA_HI_TAG_MSB:UXA_HI_TAG_LSB] & m) == (vpn & m))
                && (t == '0 || t == ptag)) begin
                hit = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end

endmodule : uxa_match

/* logic/uxa_perm.sv */
// Zone override and access permission evaluation for one matched entry.
// Assumes the zone register and mode flag are stable for the lookup cycle.
`timescale 1ns/1ps
module uxa_perm (
    input  wire logic [31:0] zone_override_reg,
    input  wire logic [3:0]  zone_pick,
    input  wire logic        user_mode_flag,
    input  wire logic        fetch_permit,
    input  wire logic        store_permit,
    output logic             deny,
    output logic             fetch_ok,
    output logic             store_ok
);
    import uxa_pkg::*;

    logic [31:0] zsh;
    logic [1:0]  zp;
    logic        grant;

    // Pick the two-bit override field, field 0 in the top bits
    assign zsh = zone_override_reg << {zone_pick, 1'b0};
    assign zp  = zsh[31:30];

    // User mode: 00 denies, 11 grants; privileged: 1x grants
    always_comb begin
        if (user_mode_flag) begin
            deny  = (zp == UXA_ZP_DENY);
            grant = (zp == UXA_ZP_GRANT);
        end else begin
            deny  = 1'b0;
            grant = zp[UXA_ZP_PRIV];
        end
    end

    // Final rights after any override
    assign fetch_ok = !deny && (fetch_permit || grant);
    assign store_ok = !deny && (store_permit || grant);

endmodule : uxa_perm

/* logic/uxa_top.sv */
// Translation entry access path and lookup for the unified buffer.
// Assumes one special register access per cycle from the core, same clock.
`timescale 1ns/1ps
module uxa_top #(
    parameter int ENTRIES             = 64,
    parameter int TAG_W               = 8,
    parameter int MMU_CONFIG          = 3,
    parameter int AREA_OPT            = 0,
    parameter int XLAT_ACCESS_LEVEL   = 3,
    parameter bit DCACHE_WB_ENABLE    = 1'b0,
    parameter bit BYTE_REVERSE_ENABLE = 1'b0
) (
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    input  wire logic                          config_load,
    input  wire logic [uxa_pkg::UXA_SEL_W-1:0] special_reg_sel,
    input  wire logic                          special_reg_read,
    input  wire logic                          special_reg_write,
    input  wire logic [31:0]                   sr_wdata,
    output logic [31:0]                        sr_rdata,
    input  wire logic                          user_mode_flag,
    input  wire logic [TAG_W-1:0]              process_tag,
    output logic                               tag_load,
    output logic [TAG_W-1:0]                   tag_load_val,
    input  wire logic [31:0]                   zone_override_reg,
    input  wire logic                          lk_req,
    input  wire logic [31:0]                   lk_vaddr,
    input  wire logic                          lk_fetch,
    input  wire logic                          lk_store,
    output logic                               lk_valid,
    output logic                               lk_hit,
    output logic [31:0]                        lk_paddr,
    output logic                               lk_fetch_fault,
    output logic                               lk_store_fault,
    output logic                               lk_write_through,
    output logic                               lk_no_cache,
    output logic                               lk_guarded,
    output logic                               lk_big_endian
);
    import uxa_pkg::*;

    localparam int IDX_W  = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam bit IMPL   = (MMU_CONFIG > UXA_MMU_USER)
                            && (AREA_OPT == UXA_AREA_PERF || AREA_OPT == UXA_AREA_FREQ);
    localparam bit ACC_OK = (XLAT_ACCESS_LEVEL > UXA_ACC_MINIMAL);
    localparam bit VIRT   = (MMU_CONFIG == UXA_MMU_VIRTUAL);

    // Entry store, cleared only by configuration load
    logic [31:0]      lo_mem    [ENTRIES];
    logic [31:0]      hi_mem    [ENTRIES];
    logic [TAG_W-1:0] owner_mem [ENTRIES];

    logic [IDX_W-1:0] idx_q;
    logic             miss_q;
    logic [31:0]      rdata_q;
    logic             tag_load_q;
    logic [TAG_W-1:0] tag_val_q;

    logic [ENTRIES*32-1:0]    hi_flat;
    logic [ENTRIES*TAG_W-1:0] owner_flat;
    logic                     wr_idx, wr_lo, wr_hi, wr_srch, rd_hi;
    logic                     s_hit, l_hit;
    logic [IDX_W-1:0]         s_idx, l_idx;
    logic [31:0]              l_lo, l_hi;
    logic [UXA_VPN_W-1:0]     l_mask;
    logic                     l_deny, l_fetch_ok, l_store_ok;
    logic [31:0]              rd_d;

    // Write side: fixed bits forced before storing
    function automatic logic [31:0] lo_fix(input logic [31:0] w);
        logic [31:0] f;
        f         = w;
        f[UXA_LO_M] = 1'b0;
        if (!DCACHE_WB_ENABLE) begin
            f[UXA_LO_W] = 1'b1;
        end
        return f;
    endfunction : lo_fix

    function automatic logic [31:0] hi_fix(input logic [31:0] w);
        logic [31:0] f;
        f                     = w;
        f[UXA_HI_CUSTOM]      = 1'b0;
        f[UXA_HI_RSV_MSB:0]   = '0;
        if (!BYTE_REVERSE_ENABLE) begin
            f[UXA_HI_E] = 1'b0;
        end
        return f;
    endfunction : hi_fix

    // Selector decode, dead when the configuration lacks the registers
    assign wr_idx  = IMPL && special_reg_write && (special_reg_sel == UXA_SEL_INDEX);
    assign wr_lo   = IMPL && special_reg_write && (special_reg_sel == UXA_SEL_LOW);
    assign wr_hi   = IMPL && special_reg_write && (special_reg_sel == UXA_SEL_HIGH);
    assign wr_srch = IMPL && special_reg_write && (special_reg_sel == UXA_SEL_SEARCH);
    assign rd_hi   = IMPL && special_reg_read && (special_reg_sel == UXA_SEL_HIGH);

    // Entry writes; no resetn term so core and debug resets keep contents
    always_ff @(posedge sys_clk) begin
        if (config_load) begin
            for (int i = 0; i < ENTRIES; i++) begin
                lo_mem[i]  <= UXA_ENTRY_RESET;
                hi_mem[i]  <= UXA_ENTRY_RESET;
                owner_mem[i] <= '0;
            end
        end else begin
            if (wr_lo) begin
                lo_mem[idx_q] <= lo_fix(sr_wdata);
            end
            if (wr_hi) begin
                hi_mem[idx_q]    <= hi_fix(sr_wdata);
                owner_mem[idx_q] <= process_tag;
            end
        end
    end

    // Flatten store for the compare units
    always_comb begin
        hi_flat  = '0;
        owner_flat = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            hi_flat[i*32 +: 32]          = hi_mem[i];
            owner_flat[i*TAG_W +: TAG_W] = owner_mem[i];
        end
    end

    // Search compare for writes to the search selector
    uxa_match #(
        .ENTRIES (ENTRIES),
        .IDX_W   (IDX_W),
        .TAG_W   (TAG_W)
    ) u_search (
        .hi_flat  (hi_flat),
        .owner_flat (owner_flat),
        .vpn        (sr_wdata[UXA_HI_TAG_MSB:UXA_HI_TAG_LSB]),
        .ptag       (process_tag),
        .hit      (s_hit),
        .idx      (s_idx)
    );

    // Index and miss flag
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            idx_q  <= '0;
            miss_q <= 1'b0;
        end else if (wr_idx) begin
            idx_q  <= sr_wdata[IDX_W-1:0];
            miss_q <= 1'b0;
        end else if (wr_srch) begin
            if (s_hit) begin
                idx_q  <= s_idx;
                miss_q <= 1'b0;
            end else begin
                miss_q <= 1'b1;
            end
        end
    end

    // Read mux, entry words and miss hidden at minimal access
    always_comb begin
        rd_d = '0;
        if (IMPL) begin
            unique case (special_reg_sel)
                UXA_SEL_INDEX: begin
                    rd_d[IDX_W-1:0]   = idx_q;
                    rd_d[UXA_IX_MISS] = miss_q && ACC_OK;
                end
                UXA_SEL_LOW: begin
                    rd_d = ACC_OK ? lo_fix(lo_mem[idx_q]) : '0;
                end
                UXA_SEL_HIGH: begin
                    rd_d = ACC_OK ? hi_mem[idx_q] : '0;
                end
                default: begin
                    rd_d = '0;
                end
            endcase
        end
    end

    // Read data register and process tag reload
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_q    <= '0;
            tag_load_q <= 1'b0;
            tag_val_q  <= '0;
        end else begin
            if (special_reg_read) begin
                rdata_q <= rd_d;
            end
            tag_load_q <= rd_hi && !user_mode_flag;
            if (rd_hi && !user_mode_flag) begin
                tag_val_q <= owner_mem[idx_q];
            end
        end
    end

    assign sr_rdata     = rdata_q;
    assign tag_load     = tag_load_q;
    assign tag_load_val = tag_val_q;

    // Translation compare for core accesses
    uxa_match #(
        .ENTRIES (ENTRIES),
        .IDX_W   (IDX_W),
        .TAG_W   (TAG_W)
    ) u_lookup (
        .hi_flat  (hi_flat),
        .owner_flat (owner_flat),
        .vpn        (lk_vaddr[UXA_HI_TAG_MSB:UXA_HI_TAG_LSB]),
        .ptag       (process_tag),
        .hit      (l_hit),
        .idx      (l_idx)
    );

    assign l_lo   = lo_fix(lo_mem[l_idx]);
    assign l_hi   = hi_mem[l_idx];
    assign l_mask = uxa_vpn_mask(l_hi[UXA_HI_SIZE_MSB:UXA_HI_SIZE_LSB]);

    uxa_perm u_perm (
        .zone_override_reg (zone_override_reg),
        .zone_pick         (l_lo[UXA_LO_ZONE_MSB:UXA_LO_ZONE_LSB]),
        .user_mode_flag    (user_mode_flag),
        .fetch_permit      (l_lo[UXA_LO_FETCH]),
        .store_permit      (l_lo[UXA_LO_WR]),
        .deny              (l_deny),
        .fetch_ok          (l_fetch_ok),
        .store_ok          (l_store_ok)
    );

    // Lookup result registers; a denied zone counts as a miss
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lk_valid         <= 1'b0;
            lk_hit           <= 1'b0;
            lk_paddr         <= '0;
            lk_fetch_fault   <= 1'b0;
            lk_store_fault   <= 1'b0;
            lk_write_through <= 1'b0;
            lk_no_cache      <= 1'b0;
            lk_guarded       <= 1'b0;
            lk_big_endian    <= 1'b0;
        end else begin
            lk_valid         <= lk_req && IMPL;
            lk_hit           <= lk_req && IMPL && l_hit && !l_deny;
            lk_fetch_fault   <= lk_req && IMPL && l_hit && !l_deny && lk_fetch && !l_fetch_ok;
            lk_store_fault   <= lk_req && IMPL && l_hit && !l_deny && lk_store && !l_store_ok;
            lk_write_through <= l_lo[UXA_LO_W];
            lk_no_cache      <= l_lo[UXA_LO_I];
            lk_guarded       <= l_lo[UXA_LO_G];
            lk_big_endian    <= l_hi[UXA_HI_E] && !lk_fetch;
            if (VIRT) begin
                lk_paddr <= {(l_lo[UXA_LO_PAGE_MSB:UXA_LO_PAGE_LSB] & l_mask)
                             | (lk_vaddr[UXA_HI_TAG_MSB:UXA_HI_TAG_LSB] & ~l_mask),
                             lk_vaddr[UXA_OFS_W-1:0]};
            end else begin
                lk_paddr <= lk_vaddr;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Checks on register access and lookup
    a_index_read: assert property (special_reg_read && IMPL && special_reg_sel == UXA_SEL_INDEX
        |=> sr_rdata[IDX_W-1:0] == $past(idx_q))
        else $error("index read returned wrong value");
    a_index_write: assert property (wr_idx ##1 !wr_srch
        |-> idx_q == $past(sr_wdata[IDX_W-1:0], 1) && !miss_q)
        else $error("index write did not load or clear miss");
    a_search_miss: assert property (wr_srch && !s_hit |=> miss_q && $stable(idx_q))
        else $error("failed search did not set miss");
    a_search_hit: assert property (wr_srch && s_hit |=> idx_q == $past(s_idx) && !miss_q)
        else $error("search hit did not load index");
    a_tag_copy: assert property (wr_hi && !config_load ##1 !config_load
        |-> owner_mem[$past(idx_q)] == $past(process_tag))
        else $error("owner tag not copied on high write");
    a_tag_load: assert property (rd_hi && !user_mode_flag
        |=> tag_load && tag_load_val == owner_mem[$past(idx_q)] ##1 !tag_load || $past(rd_hi))
        else $error("process tag reload wrong");
    a_cfg_clear: assert property (config_load |=> hi_mem[idx_q] == UXA_ENTRY_RESET
        && lo_mem[idx_q] == UXA_ENTRY_RESET && owner_mem[idx_q] == '0)
        else $error("configuration load left entry set");
    a_fetch_block: assert property (lk_req && IMPL && l_hit && lk_fetch && !user_mode_flag && !l_lo[UXA_LO_FETCH]
        && !zone_override_reg[31 - 2 * l_lo[UXA_LO_ZONE_MSB:UXA_LO_ZONE_LSB]]
        |=> lk_fetch_fault && lk_hit && lk_valid)
        else $error("blocked fetch not faulted");
    a_store_block: assert property (lk_req && IMPL && l_hit && lk_store && !user_mode_flag && !l_lo[UXA_LO_WR]
        && !zone_override_reg[31 - 2 * l_lo[UXA_LO_ZONE_MSB:UXA_LO_ZONE_LSB]]
        |=> lk_store_fault && lk_hit && lk_valid)
        else $error("blocked store not faulted");
    a_low_gate: assert property (special_reg_read && special_reg_sel == UXA_SEL_LOW
        |=> (ACC_OK && IMPL) || sr_rdata == '0)
        else $error("low word readable at minimal access");

endmodule : uxa_top

/* tb/uxa_core_model.sv */
// Core side model holding the process tag register.
// Assumes the block pulses tag_load for one cycle on a privileged high word read.
`timescale 1ns/1ps
module uxa_core_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       set_tag,
    input  wire logic [7:0] set_val,
    input  wire logic       tag_load,
    input  wire logic [7:0] tag_load_val,
    output logic [7:0]      process_tag
);
    // Tag register: software move or load from the buffer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            process_tag <= 8'h00;
        end else if (tag_load) begin
            process_tag <= tag_load_val;
        end else if (set_tag) begin
            process_tag <= set_val;
        end
    end
endmodule : uxa_core_model

/* tb/tb_unified_xlat_buffer_entry_access.sv */
// Self-checking bench for the translation entry access block.
// Assumes the core model owns the process tag; inputs driven at falling edges.
`timescale 1ns/1ps
module tb_unified_xlat_buffer_entry_access;
    import uxa_pkg::*;
    logic        sys_clk = 0, resetn = 0, config_load = 0, special_reg_read = 0, special_reg_write = 0;
    logic        user_mode_flag = 0, lk_req = 0, lk_fetch = 0, lk_store = 0, set_tag = 0, rd_seen = 0;
    logic [15:0] special_reg_sel = '0;
    logic [31:0] sr_wdata = '0, zone_override_reg = '0, lk_vaddr = '0, sr_rdata, lk_paddr, lo, hi, lo_r, hi_r, pg;
    logic [7:0]  set_val = '0, tag_load_val, process_tag, ptag;
    logic        tag_load, lk_valid, lk_hit, lk_fetch_fault, lk_store_fault;
    logic        lk_write_through, lk_no_cache, lk_guarded, lk_big_endian;
    logic [40:0] rq[$];
    logic [38:0] lq[$];
    logic [40:0] re;
    logic [38:0] le;
    integer      seed = 32'h0e124b40, failures = 0, n_tests = 0, cyc = 0;

    // Clock at 4 ns
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    uxa_top DUT (.sys_clk(sys_clk), .resetn(resetn), .config_load(config_load),
        .special_reg_sel(special_reg_sel), .special_reg_read(special_reg_read),
        .special_reg_write(special_reg_write), .sr_wdata(sr_wdata), .sr_rdata(sr_rdata),
        .user_mode_flag(user_mode_flag), .process_tag(process_tag), .tag_load(tag_load),
        .tag_load_val(tag_load_val), .zone_override_reg(zone_override_reg), .lk_req(lk_req),
        .lk_vaddr(lk_vaddr), .lk_fetch(lk_fetch), .lk_store(lk_store), .lk_valid(lk_valid),
        .lk_hit(lk_hit), .lk_paddr(lk_paddr), .lk_fetch_fault(lk_fetch_fault),
        .lk_store_fault(lk_store_fault), .lk_write_through(lk_write_through),
        .lk_no_cache(lk_no_cache), .lk_guarded(lk_guarded), .lk_big_endian(lk_big_endian));

    uxa_core_model core (.sys_clk(sys_clk), .resetn(resetn), .set_tag(set_tag), .set_val(set_val),
        .tag_load(tag_load), .tag_load_val(tag_load_val), .process_tag(process_tag));

    // Verdict and end of run
    task automatic test_done();
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Compare one value and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Special register write, one strobe cycle
    task automatic wr(input logic [15:0] sel, input logic [31:0] data);
        @(negedge sys_clk);
        special_reg_sel = sel;
        sr_wdata = data;
        special_reg_write = 1;
        @(negedge sys_clk);
        special_reg_write = 0;
    endtask : wr

    // Special register read with expected data and tag load
    task automatic rd(input logic [15:0] sel, input logic [31:0] exp, input logic etl, input logic [7:0] etv);
        rq.push_back({etl, etv, exp});
        @(negedge sys_clk);
        special_reg_sel = sel;
        special_reg_read = 1;
        @(negedge sys_clk);
        special_reg_read = 0;
    endtask : rd

    // Lookup request with expected hit and faults
    task automatic lk(input logic [31:0] va, input logic f, input logic s, input logic eh, input logic eff,
                      input logic esf);
        lq.push_back({eh, eff, esf, 1'b1, lo[UXA_LO_I], lo[UXA_LO_G], 1'b0, lo[31:10], va[9:0]});
        @(negedge sys_clk);
        lk_vaddr = va;
        lk_fetch = f;
        lk_store = s;
        lk_req = 1;
        @(negedge sys_clk);
        lk_req = 0;
    endtask : lk

    // Result watcher: a read answers the cycle after its strobe
    always @(posedge sys_clk) rd_seen <= special_reg_read;
    always @(negedge sys_clk) begin
        if (rd_seen) begin
            re = rq.pop_front();
            check("sr_rdata", sr_rdata, re[31:0]);
            check("tag_load", {31'h0, tag_load}, {31'h0, re[40]});
            if (re[40]) check("tag_load_val", {24'h0, tag_load_val}, {24'h0, re[39:32]});
        end
        if (lk_valid === 1'b1) begin
            le = lq.pop_front();
            check("lk_hit", {31'h0, lk_hit}, {31'h0, le[38]});
            check("lk_faults", {30'h0, lk_fetch_fault, lk_store_fault}, {30'h0, le[37:36]});
            if (le[38]) begin
                check("lk_attr", {28'h0, lk_write_through, lk_no_cache, lk_guarded, lk_big_endian},
                      {28'h0, le[35:32]});
                check("lk_paddr", lk_paddr, le[31:0]);
            end
        end
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 3000) begin
            failures++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(negedge sys_clk);
        resetn = 1;
        config_load = 1;
        @(negedge sys_clk);
        config_load = 0;
        ptag = 8'($random(seed));
        set_val = ptag;
        set_tag = 1;
        @(negedge sys_clk);
        set_tag = 0;
        pg = $random(seed);
        lo = {pg[21:0], 2'b10, 4'h0, 1'b1, pg[1], 1'b1, pg[0]};
        lo_r = {pg[21:0], 2'b10, 4'h0, 1'b1, pg[1], 1'b0, pg[0]};
        hi = {pg[31:10], 3'h0, 3'h7, 4'hF};
        hi_r = {pg[31:10], 3'h0, 1'b1, 6'h00};
        rd(UXA_SEL_INDEX, 32'h0, 0, 0);
        wr(UXA_SEL_INDEX, 32'h7FFFFFC5);
        rd(UXA_SEL_INDEX, 32'h5, 0, 0);
        wr(UXA_SEL_LOW, lo);
        wr(UXA_SEL_HIGH, hi);
        rd(UXA_SEL_LOW, lo_r, 0, 0);
        rd(UXA_SEL_HIGH, hi_r, 1, ptag);
        user_mode_flag = 1;
        rd(UXA_SEL_HIGH, hi_r, 0, 0);
        user_mode_flag = 0;
        rd(16'h1006, 32'h0, 0, 0);
        wr(UXA_SEL_SEARCH, {~pg[31:10], 10'h0});
        rd(UXA_SEL_INDEX, 32'h80000005, 0, 0);
        wr(UXA_SEL_INDEX, 32'h0);
        wr(UXA_SEL_SEARCH, {pg[31:10], 10'h0});
        rd(UXA_SEL_INDEX, 32'h5, 0, 0);
        lk({pg[31:10], 10'h2A5}, 1, 0, 1, 0, 0);
        lk({pg[31:10], 10'h013}, 0, 1, 1, 0, 1);
        lk({~pg[31:10], 10'h013}, 1, 0, 0, 0, 0);
        zone_override_reg = 32'h80000000;
        lk({pg[31:10], 10'h3FF}, 0, 1, 1, 0, 0);
        user_mode_flag = 1;
        lk({pg[31:10], 10'h001}, 0, 1, 1, 0, 1);
        zone_override_reg = 32'h00000000;
        lk({pg[31:10], 10'h001}, 1, 0, 0, 0, 0);
        zone_override_reg = 32'hC0000000;
        lk({pg[31:10], 10'h100}, 0, 1, 1, 0, 0);
        user_mode_flag = 0;
        zone_override_reg = 32'h00000000;
        lo[9:8] = 2'b01;
        lo_r[9:8] = 2'b01;
        wr(UXA_SEL_LOW, lo);
        lk({pg[31:10], 10'h055}, 1, 0, 1, 1, 0);
        lk({pg[31:10], 10'h0AA}, 0, 1, 1, 0, 0);
        @(negedge sys_clk);
        resetn = 0;
        repeat (2) @(negedge sys_clk);
        resetn = 1;
        rd(UXA_SEL_INDEX, 32'h0, 0, 0);
        wr(UXA_SEL_INDEX, 32'h5);
        rd(UXA_SEL_LOW, lo_r, 0, 0);
        @(negedge sys_clk);
        config_load = 1;
        @(negedge sys_clk);
        config_load = 0;
        rd(UXA_SEL_LOW, 32'h8, 0, 0);
        rd(UXA_SEL_HIGH, 32'h0, 1, 8'h00);
        repeat (4) @(negedge sys_clk);
        check("lk_pending", lq.size(), 32'h0);
        check("rd_pending", rq.size(), 32'h0);
        test_done();
    end
endmodule : tb_unified_xlat_buffer_entry_access
